// ===== swm_consts.vh
// timing constants and command codes for the single-wire bus master
`ifndef SWM_CONSTS_VH
`define SWM_CONSTS_VH
`define SWM_CLK_MHZ          200
`define SWM_RESET_LOW_US     480
`define SWM_RESET_HIGH_US    480
`define SWM_SLOT_US          70
`define SWM_WRITE1_LOW_US    6
`define SWM_WRITE0_LOW_US    60
`define SWM_READ_LOW_US      2
`define SWM_READ_SAMPLE_US   12
`define SWM_RECOVERY_US      5
`define SWM_PRES_WIN_LO_US   15
`define SWM_PRES_WIN_HI_US   300
`define SWM_RESET_LOW_CYC    (`SWM_RESET_LOW_US * `SWM_CLK_MHZ)
`define SWM_RESET_HIGH_CYC   (`SWM_RESET_HIGH_US * `SWM_CLK_MHZ)
`define SWM_SLOT_CYC         (`SWM_SLOT_US * `SWM_CLK_MHZ)
`define SWM_WRITE1_LOW_CYC   (`SWM_WRITE1_LOW_US * `SWM_CLK_MHZ)
`define SWM_WRITE0_LOW_CYC   (`SWM_WRITE0_LOW_US * `SWM_CLK_MHZ)
`define SWM_READ_LOW_CYC     (`SWM_READ_LOW_US * `SWM_CLK_MHZ)
`define SWM_READ_SAMPLE_CYC  (`SWM_READ_SAMPLE_US * `SWM_CLK_MHZ)
`define SWM_RECOVERY_CYC     (`SWM_RECOVERY_US * `SWM_CLK_MHZ)
`define SWM_PRES_WIN_LO_CYC  (`SWM_PRES_WIN_LO_US * `SWM_CLK_MHZ)
`define SWM_PRES_WIN_HI_CYC  (`SWM_PRES_WIN_HI_US * `SWM_CLK_MHZ)
`define SWM_CMD_MATCH        8'h55
`define SWM_CMD_SEARCH       8'hf0
`define SWM_CMD_ACTIVE       8'hec
`define SWM_CMD_SKIP         8'hcc
`define SWM_OP_RESET         2'h0
`define SWM_OP_WRITE         2'h1
`define SWM_OP_READ          2'h2
`define SWM_OP_TRIPLET       2'h3
`define SWM_CRC_POLY_REFL    8'h8c
`endif

// ===== swm_master.v
// single-wire bus master: reset/presence, bit slots, search triplets and check code
//
// Notes on behaviour
// - master drives reset low 480 us minimum
// - every slot starts with master falling edge
// - master samples read data before 15 us
// - master waits 480 us high after reset
// - reset low plus rise under 960 us
// - check code polynomial x8 x5 x4 plus 1
// - search: bit, complement, then master choice
`timescale 1ns/1ps
`include "swm_consts.vh"

module swm_master #(
	parameter RESET_LOW_CYC  = `SWM_RESET_LOW_CYC,
	parameter RESET_HIGH_CYC = `SWM_RESET_HIGH_CYC,
	parameter SLOT_CYC       = `SWM_SLOT_CYC,
	parameter W1_LOW_CYC     = `SWM_WRITE1_LOW_CYC,
	parameter W0_LOW_CYC     = `SWM_WRITE0_LOW_CYC,
	parameter RD_LOW_CYC     = `SWM_READ_LOW_CYC,
	parameter RD_SAMPLE_CYC  = `SWM_READ_SAMPLE_CYC,
	parameter RECOVERY_CYC   = `SWM_RECOVERY_CYC,
	parameter PRES_LO_CYC    = `SWM_PRES_WIN_LO_CYC,
	parameter PRES_HI_CYC    = `SWM_PRES_WIN_HI_CYC
) (
	input  wire       i_ref_clk,
	input  wire       i_sys_rst,
	input  wire       i_req_valid,
	input  wire [1:0] i_req_op,
	input  wire [7:0] i_req_data,
	input  wire [3:0] i_req_bits,
	input  wire       i_crc_clear,
	output wire       o_req_ready,
	output reg        o_done,
	output reg  [7:0] o_rd_data,
	output reg        o_presence,
	output reg  [1:0] o_trip_bits,
	output reg        o_trip_dir,
	output reg  [7:0] o_crc,
	output wire       o_crc_ok,
	input  wire       i_line,
	output wire       o_line,
	output wire       o_line_oe
);

	localparam CW = 20;
	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_RLOW = 7'h02;
	localparam [6:0] ST_RHI  = 7'h04;
	localparam [6:0] ST_SLOT = 7'h08;
	localparam [6:0] ST_REC  = 7'h10;
	localparam [6:0] ST_NEXT = 7'h20;
	localparam [6:0] ST_DONE = 7'h40;
	// counts cut to the counter width on purpose; every default fits in 20 bits
	localparam [CW-1:0] C_RLOW = RESET_LOW_CYC[CW-1:0];
	localparam [CW-1:0] C_RHI  = RESET_HIGH_CYC[CW-1:0];
	localparam [CW-1:0] C_SLOT = SLOT_CYC[CW-1:0];
	localparam [CW-1:0] C_W1   = W1_LOW_CYC[CW-1:0];
	localparam [CW-1:0] C_W0   = W0_LOW_CYC[CW-1:0];
	localparam [CW-1:0] C_RDL  = RD_LOW_CYC[CW-1:0];
	localparam [CW-1:0] C_RDS  = RD_SAMPLE_CYC[CW-1:0];
	localparam [CW-1:0] C_REC  = RECOVERY_CYC[CW-1:0];
	localparam [CW-1:0] C_PLO  = PRES_LO_CYC[CW-1:0];
	localparam [CW-1:0] C_PHI  = PRES_HI_CYC[CW-1:0];

	reg [6:0]    state_q;
	reg [CW-1:0] cnt_q;
	reg [1:0]    op_q;
	reg [7:0]    shift_q;
	reg [3:0]    nbits_q;
	reg [3:0]    bitno_q;
	reg [1:0]    phase_q;
	reg          wbit_q;
	reg          rbit_q;
	reg          drive_q;
	reg [1:0]    trip_q;

	// line is open drain: only ever pull low, never drive high
	assign o_line    = 1'b0;
	assign o_line_oe = drive_q;
	assign o_req_ready = (state_q == ST_IDLE);
	assign o_crc_ok  = (o_crc == 8'h00);

	// triplet phases 0 and 1 are read slots, phase 2 writes the chosen direction
	wire slot_is_read = (op_q == `SWM_OP_READ) || (op_q == `SWM_OP_TRIPLET && phase_q != 2'd2);
	wire crc_fb = o_crc[0] ^ rbit_q;

	// main sequencer
	always @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_q     <= ST_IDLE;
			cnt_q       <= {CW{1'b0}};
			op_q        <= 2'h0;
			shift_q     <= 8'h00;
			nbits_q     <= 4'h0;
			bitno_q     <= 4'h0;
			phase_q     <= 2'h0;
			wbit_q      <= 1'b0;
			rbit_q      <= 1'b0;
			drive_q     <= 1'b0;
			trip_q      <= 2'h0;
			o_done      <= 1'b0;
			o_rd_data   <= 8'h00;
			o_presence  <= 1'b0;
			o_trip_bits <= 2'h0;
			o_trip_dir  <= 1'b0;
			o_crc       <= 8'h00;
		end else begin
			o_done <= 1'b0;
			if (i_crc_clear && state_q == ST_IDLE)
				o_crc <= 8'h00;
			case (state_q)
			ST_IDLE: begin
				if (i_req_valid) begin
					op_q    <= i_req_op;
					shift_q <= i_req_data;
					nbits_q <= (i_req_bits == 4'h0) ? 4'h1 : ((i_req_bits > 4'h8) ? 4'h8 : i_req_bits);
					bitno_q <= 4'h0;
					phase_q <= 2'h0;
					cnt_q   <= {CW{1'b0}};
					if (i_req_op == `SWM_OP_RESET) begin
						drive_q    <= 1'b1; // reset pulse
						o_presence <= 1'b0;
						state_q    <= ST_RLOW;
					end else begin
						state_q <= ST_SLOT;
						drive_q <= 1'b1; // falling edge opens slot
						wbit_q  <= (i_req_op == `SWM_OP_WRITE) ? i_req_data[0] : 1'b1; // lsb first
					end
				end
			end
			ST_RLOW: begin
				// fixed 480 us keeps low plus rise well under 960 us
				if (cnt_q == C_RLOW - 1'b1) begin
					drive_q <= 1'b0;
					cnt_q   <= {CW{1'b0}};
					state_q <= ST_RHI;
				end else
					cnt_q <= cnt_q + 1'b1;
			end
			ST_RHI: begin
				// presence sampled in its window after release
				if (cnt_q >= C_PLO && cnt_q <= C_PHI && !i_line)
					o_presence <= 1'b1;
				// no new request until high interval served
				if (cnt_q == C_RHI - 1'b1)
					state_q <= ST_DONE;
				else
					cnt_q <= cnt_q + 1'b1;
			end
			ST_SLOT: begin
				// release after write low time or short read pulse
				if (slot_is_read) begin
					if (cnt_q == C_RDL - 1'b1)
						drive_q <= 1'b0;
				end else if (cnt_q == (wbit_q ? C_W1 : C_W0) - 1'b1)
					drive_q <= 1'b0;
				// device holds low for a zero; sample before 15 us
				if (slot_is_read && cnt_q == C_RDS - 1'b1)
					rbit_q <= i_line;
				if (cnt_q == C_SLOT - 1'b1) begin
					cnt_q   <= {CW{1'b0}};
					state_q <= ST_REC;
				end else
					cnt_q <= cnt_q + 1'b1;
			end
			ST_REC: begin
				if (cnt_q == C_REC - 1'b1) begin
					cnt_q   <= {CW{1'b0}};
					state_q <= ST_NEXT;
				end else
					cnt_q <= cnt_q + 1'b1;
			end
			ST_NEXT: begin
				state_q <= ST_SLOT;
				drive_q <= 1'b1;
				if (op_q == `SWM_OP_TRIPLET) begin
					// bit, complement, then chosen direction
					if (phase_q == 2'd0) begin
						trip_q[0] <= rbit_q;
						phase_q   <= 2'd1;
						wbit_q    <= 1'b1;
					end else if (phase_q == 2'd1) begin
						trip_q[1] <= rbit_q;
						phase_q   <= 2'd2;
						// {complement,bit}: 01 all one, 10 all zero; 00 and 11 take the latched caller bit
						wbit_q    <= ({rbit_q, trip_q[0]} == 2'b01) ? 1'b1 :
							({rbit_q, trip_q[0]} == 2'b10) ? 1'b0 : shift_q[0];
					end else begin
						o_trip_bits <= trip_q;
						o_trip_dir  <= wbit_q;
						// identity check code over chosen bits
						o_crc   <= (o_crc >> 1) ^ ((o_crc[0] ^ wbit_q) ? `SWM_CRC_POLY_REFL : 8'h00);
						drive_q <= 1'b0;
						state_q <= ST_DONE;
					end
				end else begin
					if (op_q == `SWM_OP_READ) begin
						shift_q <= {rbit_q, shift_q[7:1]};
						o_crc   <= (o_crc >> 1) ^ (crc_fb ? `SWM_CRC_POLY_REFL : 8'h00);
					end else
						shift_q <= {1'b0, shift_q[7:1]};
					if (bitno_q == nbits_q - 1'b1) begin
						drive_q <= 1'b0;
						state_q <= ST_DONE;
					end else begin
						bitno_q <= bitno_q + 1'b1;
						wbit_q  <= (op_q == `SWM_OP_WRITE) ? shift_q[1] : 1'b1; // lsb first
					end
				end
			end
			ST_DONE: begin
				// read bits land right-aligned in the low positions
				if (op_q == `SWM_OP_READ)
					o_rd_data <= shift_q >> (4'h8 - nbits_q);
				o_done  <= 1'b1;
				state_q <= ST_IDLE;
			end
			default: begin
				state_q <= ST_IDLE;
				drive_q <= 1'b0;
			end
			endcase
		end
	end

endmodule // swm_master

// ===== swm_master_props.sv
// assertions on the bus master ports
`timescale 1ns/1ps
module swm_props #(
	parameter RESET_LOW_CYC  = 200,
	parameter RESET_HIGH_CYC = 200
) (
	input wire       i_ref_clk,
	input wire       i_sys_rst,
	input wire       i_req_valid,
	input wire [1:0] i_req_op,
	input wire [7:0] i_req_data,
	input wire       i_crc_clear,
	input wire       o_req_ready,
	input wire       o_done,
	input wire [7:0] o_crc,
	input wire       o_line_oe
);
	reg  [31:0] lo_q;
	reg  [31:0] hi_q;
	reg         rf_q;
	wire        tk = i_req_valid && o_req_ready;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	// run lengths of driven and released wire; rf_q marks a reset-length low
	always @(posedge i_ref_clk) begin
		lo_q <= (i_sys_rst || !o_line_oe) ? 32'h0 : lo_q + 32'h1;
		hi_q <= (i_sys_rst || o_line_oe) ? 32'h0 : hi_q + 32'h1;
		if (i_sys_rst) rf_q <= 1'b0;
		else if ($fell(o_line_oe)) rf_q <= lo_q >= RESET_LOW_CYC - 1;
	end
	property p_rst_low; $fell(o_line_oe) |-> lo_q < 40 || lo_q >= RESET_LOW_CYC - 1; endproperty
	a_rst_low: assert property (p_rst_low) else $error("reset low too short");
	property p_low_max; o_line_oe |-> lo_q < 2 * RESET_LOW_CYC; endproperty
	a_low_max: assert property (p_low_max) else $error("line held low too long");
	property p_rst_high; $rose(o_line_oe) && rf_q |-> hi_q >= RESET_HIGH_CYC; endproperty
	a_rst_high: assert property (p_rst_high) else $error("traffic inside reset high time");
	property p_start; tk |=> o_line_oe; endproperty
	a_start: assert property (p_start) else $error("operation did not start with a low");
	property p_read; tk && i_req_op == 2'h2 |=> o_line_oe ##[1:2] !o_line_oe; endproperty
	a_read: assert property (p_read) else $error("read low too long");
	property p_wr1; tk && i_req_op == 2'h1 && i_req_data[0] |=> o_line_oe[*2] ##[1:3] !o_line_oe; endproperty
	a_wr1: assert property (p_wr1) else $error("first bit one not short low");
	property p_wr0; tk && i_req_op == 2'h1 && !i_req_data[0] |=> o_line_oe[*8]; endproperty
	a_wr0: assert property (p_wr0) else $error("first bit zero not long low");
	property p_clr; i_crc_clear && o_req_ready |=> o_crc == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("check code not cleared");
	property p_trip; tk && i_req_op == 2'h3 |=> !o_req_ready[*8] ##[100:200] o_done; endproperty
	a_trip: assert property (p_trip) else $error("triplet not three slots");
endmodule // swm_props
bind swm_master swm_props #(.RESET_LOW_CYC(RESET_LOW_CYC), .RESET_HIGH_CYC(RESET_HIGH_CYC)) u_props (.*);

// ===== swm_dev_model.sv
// behavioural addressable switch at the far end of the wire
`timescale 1ns/1ps
module swm_dev_model (
	input  wire        i_ref_clk,
	input  wire        i_line,
	input  wire [63:0] i_id,
	output reg         o_pull
);
	reg        pd_q = 1'b1; // pulldown command, survives resets
	reg [15:0] low_q = 16'h0;
	// a long low restarts the protocol wherever it stands
	always @(posedge i_ref_clk) begin
		low_q <= i_line ? 16'h0 : low_q + 16'h1;
		if (low_q == 16'h64) begin
			disable body;
			o_pull <= 1'b0;
		end
	end
	// slot timed from the master's falling edge
	task slot(input d, output b);
		begin
			@(negedge i_line);
			o_pull = d; // zero sent by holding low
			repeat (12) @(posedge i_ref_clk);
			o_pull = 1'b0;
			repeat (3) @(posedge i_ref_clk);
			b = i_line; // written bit at fixed delay
		end
	endtask
	// presence, command, selection, then status reads until reset
	always begin : body
		integer i;
		reg [7:0] c;
		reg b, m;
		o_pull = 1'b0;
		wait (low_q > 16'h60);
		wait (i_line);
		repeat (10) @(posedge i_ref_clk);
		o_pull = 1'b1;
		repeat (30) @(posedge i_ref_clk);
		o_pull = 1'b0;
		for (i = 0; i < 8; i = i + 1) slot(1'b0, c[i]); // lsb first
		m = 1'b1;
		if (c == 8'h55) begin
			for (i = 0; i < 64; i = i + 1) begin
				slot(1'b0, b);
				m = m & (b == i_id[i]);
			end
			if (m) pd_q = !pd_q; // toggle after last bit
			else wait (1'b0);
		end else if (c == 8'hf0 || (c == 8'hec && pd_q)) begin
			for (i = 0; i < 64; i = i + 1) begin
				slot(!i_id[i], b);
				slot(i_id[i], b);
				slot(1'b0, b);
				if (b != i_id[i]) wait (1'b0); // drop out until reset
			end
		end else wait (1'b0); // skip or inactive: silent
		forever slot(pd_q, b); // no toggle; low while pulled down
	end
endmodule // swm_dev_model

// ===== test_swm_master.sv
// testbench for the bus master against the switch model
`timescale 1ns/1ps
module test_swm_master;
	reg         i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_req_valid = 1'b0, i_crc_clear = 1'b0;
	reg  [1:0]  i_req_op = 2'h0;
	reg  [7:0]  i_req_data = 8'h00;
	reg  [3:0]  i_req_bits = 4'h8;
	wire        o_req_ready, o_done, o_presence, o_trip_dir, o_crc_ok, o_line, o_line_oe, pull, i_line;
	wire [7:0]  o_rd_data, o_crc;
	wire [1:0]  o_trip_bits;
	reg  [63:0] id;
	integer     fail_count = 0, total_checks = 0, pd = 1, i;
	assign i_line = !(o_line_oe || pull); // pull-up when nobody drives
	// shortened timing so a full search pass fits the run
	localparam integer T_RLOW = 200, T_RHI = 200, T_SLOT = 40, T_W1 = 3, T_W0 = 30;
	localparam integer T_RDL = 1, T_RDS = 6, T_REC = 3, T_PLO = 5, T_PHI = 150;
	swm_master #(.RESET_LOW_CYC(T_RLOW), .RESET_HIGH_CYC(T_RHI), .SLOT_CYC(T_SLOT), .W1_LOW_CYC(T_W1),
		.W0_LOW_CYC(T_W0), .RD_LOW_CYC(T_RDL), .RD_SAMPLE_CYC(T_RDS), .RECOVERY_CYC(T_REC),
		.PRES_LO_CYC(T_PLO), .PRES_HI_CYC(T_PHI)) uut (.*);
	swm_dev_model dev (.i_ref_clk(i_ref_clk), .i_line(i_line), .i_id(id), .o_pull(pull));
	always #2.5 i_ref_clk = ~i_ref_clk;
	task final_report;
		begin
			if (fail_count == 0 && total_checks > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// one request, then wait for its done pulse
	task op(input [1:0] o, input [7:0] d);
		integer k;
		begin
			@(posedge i_ref_clk);
			i_req_valid <= 1'b1;
			i_req_op <= o;
			i_req_data <= d;
			@(posedge i_ref_clk);
			i_req_valid <= 1'b0;
			for (k = 0; k < 9000 && o_done !== 1'b1; k = k + 1) @(negedge i_ref_clk);
			chk({7'h0, o_done}, 8'h01);
		end
	endtask
	// own check code, reflected form of x8+x5+x4+1
	function [7:0] crc8(input [55:0] v);
		integer j;
		reg [7:0] r;
		begin
			r = 8'h00;
			for (j = 0; j < 56; j = j + 1) r = (r >> 1) ^ ((r[0] ^ v[j]) ? 8'h8c : 8'h00);
			crc8 = r;
		end
	endfunction
	// full search pass; conflict direction set wrong so only agreement passes
	task search(input [7:0] c);
		integer j;
		begin
			op(2'h0, 8'h00);
			chk({7'h0, o_presence}, 8'h01);
			chk({7'h0, o_line}, 8'h00);
			op(2'h1, c);
			@(posedge i_ref_clk);
			i_crc_clear <= 1'b1;
			@(posedge i_ref_clk);
			i_crc_clear <= 1'b0;
			for (j = 0; j < 64; j = j + 1) begin
				op(2'h3, {7'h0, !id[j]});
				chk({5'h0, o_trip_bits, o_trip_dir}, {5'h0, !id[j], id[j], id[j]});
			end
			chk(o_crc, 8'h00);
			chk({7'h0, o_crc_ok}, 8'h01);
			op(2'h2, 8'h00);
			chk(o_rd_data, 8'h00);
		end
	endtask
	initial begin
		#500000;
		fail_count = fail_count + 1;
		final_report;
	end
	initial begin
		id[31:0] = $urandom(32'h4274c270);
		id[55:32] = $urandom;
		id[63:56] = crc8(id[55:0]);
		repeat (12) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		search(8'hec);
		search(8'hf0);
		op(2'h0, 8'h00);
		op(2'h1, 8'h55);
		for (i = 0; i < 8; i = i + 1) op(2'h1, id[8 * i +: 8]);
		pd = 1 - pd;
		op(2'h2, 8'h00);
		chk(o_rd_data, pd ? 8'h00 : 8'hff);
		// short reads land right-aligned; a zero count means one bit
		@(posedge i_ref_clk);
		i_req_bits <= 4'h3;
		op(2'h2, 8'h00);
		chk(o_rd_data, pd ? 8'h00 : 8'h07);
		@(posedge i_ref_clk);
		i_req_bits <= 4'h0;
		op(2'h2, 8'h00);
		chk(o_rd_data, pd ? 8'h00 : 8'h01);
		@(posedge i_ref_clk);
		i_req_bits <= 4'h8;
		op(2'h0, 8'h00);
		op(2'h1, 8'hec);
		op(2'h3, 8'h00);
		chk({6'h0, o_trip_bits}, 8'h03);
		op(2'h0, 8'h00);
		op(2'h1, 8'hcc);
		op(2'h2, 8'h00);
		chk(o_rd_data, 8'hff);
		final_report;
	end
endmodule // test_swm_master
